// ==== clock_router_defines.vh ====
`ifndef CLOCK_ROUTER_DEFINES_VH
`define CLOCK_ROUTER_DEFINES_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ        10000000
`define TOL_PCT       3
`define PEAK_HOLD_MS  90
`define HOLD_W        20
`define WC_TIMEOUT    9'd300
`define LOCK_GOOD     2'd2

// ----------------------------------------------------------------
// rate codes and frequencies
// ----------------------------------------------------------------
`define RATE_44K1     3'd0
`define RATE_48K      3'd1
`define RATE_88K2     3'd2
`define RATE_96K      3'd3
`define RATE_176K4    3'd4
`define RATE_192K     3'd5
`define RATE_EXT      3'd6
`define HZ_44K1       44100
`define HZ_48K        48000
`define HZ_88K2       88200
`define HZ_96K        96000
`define HZ_176K4      176400
`define HZ_192K       192000

// ----------------------------------------------------------------
// meter thresholds, magnitude of 24-bit full scale
// ----------------------------------------------------------------
`define LVL_M37_DB    24'd118490
`define LVL_M6_DB     24'd4204263
`define LVL_M1_DB     24'd7476354

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define REG_CTRL      3'd0
`define REG_STATUS    3'd1
`define REG_IRQ_STAT  3'd2
`define REG_IRQ_MASK  3'd3
`define REG_PERIOD    3'd4
`define CTRL_RES_BIT  0
`define CTRL_RATE_LSB 1
`define CTRL_RESET    8'h03
`define IRQ_LOCK_UP   0
`define IRQ_LOCK_DOWN 1
`define IRQ_CLIP      2

`endif

// ==== converter_clock_router.v ====
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "clock_router_defines.vh"

module converter_clock_router #(
  parameter integer HOLD_CYCLES = `PEAK_HOLD_MS * (`CLK_HZ / 1000)
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         cyc_i,
  input  wire         stb_i,
  input  wire         we_i,
  input  wire [7:0]   adr_i,
  input  wire [3:0]   sel_i,
  input  wire [31:0]  dat_i,
  output wire [31:0]  dat_o,
  output wire         ack_o,
  output wire         irq_o,
  input  wire         wc_i,
  input  wire [191:0] adc_data_i,
  input  wire         adc_valid_i,
  output wire         wc_o,
  output wire [2:0]   rate_o,
  output wire         frame_o,
  output wire [191:0] aes_data_o,
  output wire [191:0] opt1_data_o,
  output wire [191:0] opt2_data_o,
  output wire [7:0]   led_low_green_o,
  output wire [7:0]   led_up_yellow_o,
  output wire [7:0]   led_up_red_o,
  output wire         led_lock_green_o,
  output wire         led_lock_red_o
);

  // ----------------------------------------------------------------
  // rate helpers
  // ----------------------------------------------------------------
  function integer rate_hz;
    input [2:0] code;
    begin
      case (code)
        `RATE_44K1:  rate_hz = `HZ_44K1;
        `RATE_88K2:  rate_hz = `HZ_88K2;
        `RATE_96K:   rate_hz = `HZ_96K;
        `RATE_176K4: rate_hz = `HZ_176K4;
        `RATE_192K:  rate_hz = `HZ_192K;
        default:     rate_hz = `HZ_48K;
      endcase
    end
  endfunction

  // period window in clk cycles for +-tolerance on frequency
  function [3:0] match_rate;
    input [8:0] p;
    integer k;
    integer r;
    integer lo;
    integer hi;
    begin
      match_rate = 4'h0;
      for (k = 0; k < 6; k = k + 1)
      begin
        r  = rate_hz(k[2:0]);
        lo = (`CLK_HZ * 100 + r * (100 + `TOL_PCT) - 1) / (r * (100 + `TOL_PCT));
        hi = (`CLK_HZ * 100) / (r * (100 - `TOL_PCT));
        if (p >= lo && p <= hi)
          match_rate = {1'b1, k[2:0]};
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [7:0]   ctrl_reg;
  reg  [2:0]   irq_stat_reg;
  reg  [2:0]   irq_mask_reg;
  reg          ack_reg;
  reg  [31:0]  dat_reg;
  reg          irq_reg;
  reg          wc_s1_reg;
  reg          wc_s2_reg;
  reg          wc_s3_reg;
  reg  [8:0]   cnt_reg;
  reg  [8:0]   period_reg;
  reg  [2:0]   det_rate_reg;
  reg  [1:0]   good_reg;
  reg          ext_lock_reg;
  reg  [23:0]  acc_reg;
  reg          nco_reg;
  reg          wc_out_reg;
  reg          wc_prev_reg;
  reg          frame_reg;
  reg  [31:0]  lfsr_reg;
  reg  [191:0] adc_reg;
  reg  [191:0] aes_reg;
  reg  [191:0] opt1_reg;
  reg  [191:0] opt2_reg;
  reg          lock_g_reg;
  reg          lock_r_reg;
  reg  [2:0]   rate_reg;
  wire [7:0]   low_led;
  wire [7:0]   yel_led;
  wire [7:0]   red_led;

  wire [2:0]   sel_rate = ctrl_reg[`CTRL_RATE_LSB +: 3];
  wire         ext_mode = (sel_rate > `RATE_192K);
  wire         locked   = !ext_mode || ext_lock_reg;
  wire         muted    = !locked;
  wire [2:0]   eff_rate = !ext_mode ? sel_rate :
                          (ext_lock_reg ? det_rate_reg : `RATE_48K);

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  wire         req      = cyc_i && stb_i && !ack_reg;
  wire         wr       = req && we_i && sel_i[0];
  wire         rd_stat  = req && !we_i && (adr_i[4:2] == `REG_IRQ_STAT);
  wire [2:0]   ev;
  reg  [31:0]  rd_mux;

  always @*
  begin
    case (adr_i[4:2])
      `REG_CTRL:     rd_mux = {24'h000000, ctrl_reg};
      `REG_STATUS:   rd_mux = {26'h0, muted, eff_rate, ext_mode, locked};
      `REG_IRQ_STAT: rd_mux = {29'h0, irq_stat_reg};
      `REG_IRQ_MASK: rd_mux = {29'h0, irq_mask_reg};
      `REG_PERIOD:   rd_mux = {23'h0, period_reg};
      default:       rd_mux = 32'h00000000;
    endcase
  end

  wire [2:0] stat_next = (rd_stat ? 3'h0 : irq_stat_reg) | ev; // set beats read clear

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg     <= `CTRL_RESET;
      irq_stat_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
      ack_reg      <= 1'b0;
      dat_reg      <= 32'h00000000;
      irq_reg      <= 1'b0;
    end
    else
    begin
      ack_reg      <= req;
      dat_reg      <= req && !we_i ? rd_mux : 32'h00000000;
      irq_stat_reg <= stat_next;
      irq_reg      <= |(stat_next & irq_mask_reg);
      if (wr && adr_i[4:2] == `REG_CTRL)
        ctrl_reg <= dat_i[7:0];
      if (wr && adr_i[4:2] == `REG_IRQ_MASK)
        irq_mask_reg <= dat_i[2:0];
    end
  end

  // ----------------------------------------------------------------
  // word clock input: sync, period measure, lock
  // ----------------------------------------------------------------
  // resolution is one clk period, so the tolerance edges blur by one count
  wire       wc_rise = wc_s2_reg && !wc_s3_reg;
  wire [3:0] m       = match_rate(cnt_reg);

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wc_s1_reg    <= 1'b0;
      wc_s2_reg    <= 1'b0;
      wc_s3_reg    <= 1'b0;
      cnt_reg      <= 9'd0;
      period_reg   <= 9'd0;
      det_rate_reg <= `RATE_48K;
      good_reg     <= 2'd0;
      ext_lock_reg <= 1'b0;
    end
    else
    begin
      wc_s1_reg <= wc_i;
      wc_s2_reg <= wc_s1_reg;
      wc_s3_reg <= wc_s2_reg;
      if (wc_rise)
      begin
        cnt_reg    <= 9'd1;
        period_reg <= cnt_reg;
        if (m[3] && m[2:0] == det_rate_reg)
        begin
          if (good_reg == `LOCK_GOOD)
            ext_lock_reg <= 1'b1;
          else
            good_reg <= good_reg + 2'd1;
        end
        else
        begin
          det_rate_reg <= m[3] ? m[2:0] : det_rate_reg;
          good_reg     <= 2'd0;
          ext_lock_reg <= 1'b0;
        end
      end
      else if (cnt_reg >= `WC_TIMEOUT)
      begin
        good_reg     <= 2'd0;
        ext_lock_reg <= 1'b0;
      end
      else
        cnt_reg <= cnt_reg + 9'd1;
    end
  end

  // ----------------------------------------------------------------
  // word clock output and frame strobe
  // ----------------------------------------------------------------
  // fractional divider: average rate exact, edges jitter by one clk
  wire [31:0] nco_inc32 = 2 * rate_hz(eff_rate);
  wire [23:0] nco_inc  = nco_inc32[23:0];
  wire [24:0] nco_sum = {1'b0, acc_reg} + {1'b0, nco_inc};
  wire [31:0] nco_rem  = nco_sum - `CLK_HZ;
  wire        nco_wrap = (nco_sum >= `CLK_HZ);

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc_reg     <= 24'h000000;
      nco_reg     <= 1'b0;
      wc_out_reg  <= 1'b0;
      wc_prev_reg <= 1'b0;
      frame_reg   <= 1'b0;
      lfsr_reg    <= 32'h0000_0001;
    end
    else
    begin
      acc_reg <= nco_wrap ? nco_rem[23:0] : nco_sum[23:0];
      if (nco_wrap)
        nco_reg <= !nco_reg;
      // mirror lags the input by the sync stages plus one
      wc_out_reg  <= (ext_mode && ext_lock_reg) ? wc_s3_reg : nco_reg;
      wc_prev_reg <= wc_out_reg;
      frame_reg   <= wc_out_reg && !wc_prev_reg;
      lfsr_reg    <= {lfsr_reg[30:0],
                      lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
    end
  end

  // ----------------------------------------------------------------
  // per channel word length and metering
  // ----------------------------------------------------------------
  wire [191:0] word_all;
  wire [7:0]   clip_new;
  wire [63:0]  lfsr_dbl = {lfsr_reg, lfsr_reg};

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : ch
      wire signed [23:0] s   = adc_reg[g*24 +: 24];
      wire [15:0]        rv  = lfsr_dbl[g*4 +: 16];
      wire signed [9:0]  dith = $signed({2'b00, rv[7:0]}) - $signed({2'b00, rv[15:8]});
      wire signed [25:0] sum = {{2{s[23]}}, s} + {{16{dith[9]}}, dith} + 26'sd128;
      wire [17:0]        q   = sum[25:8];
      wire               ovf = (q[17:15] != 3'b000) && (q[17:15] != 3'b111);
      wire [15:0]        q16 = ovf ? (q[17] ? 16'h8000 : 16'h7FFF) : q[15:0];
      wire [23:0]        mag = s[23] ? (~s + 24'h000001) : s;
      wire               hi1 = (mag > `LVL_M1_DB);
      wire               hi6 = (mag >= `LVL_M6_DB);
      reg  [`HOLD_W-1:0] hold_reg;
      reg  [1:0]         pk_reg;
      reg                hi1_d_reg;
      reg  [2:0]         led_bits_reg;

      assign word_all[g*24 +: 24] = ctrl_reg[`CTRL_RES_BIT] ? s : {q16, 8'h00};
      assign clip_new[g]          = hi1 && !hi1_d_reg;
      assign {red_led[g], yel_led[g], low_led[g]} = led_bits_reg;

      always @(posedge clk_i)
      begin
        if (rst_i)
        begin
          hold_reg   <= {`HOLD_W{1'b0}};
          pk_reg     <= 2'd0;
          hi1_d_reg  <= 1'b0;
          led_bits_reg <= 3'b000;
        end
        else
        begin
          hi1_d_reg  <= hi1;
          led_bits_reg[0] <= (mag >= `LVL_M37_DB) && !hi6;
          if (hi1 || (hi6 && pk_reg != 2'd2))
          begin
            pk_reg   <= hi1 ? 2'd2 : 2'd1;
            hold_reg <= HOLD_CYCLES[`HOLD_W-1:0];
          end
          else if (hold_reg != {`HOLD_W{1'b0}})
            hold_reg <= hold_reg - 1'b1;
          else
            pk_reg <= 2'd0;
          led_bits_reg[1] <= (pk_reg == 2'd1);
          led_bits_reg[2] <= (pk_reg == 2'd2);
        end
      end
    end
  endgenerate

  // lock lost covers a bad period and a dead input alike
  wire wc_hit    = m[3] && (m[2:0] == det_rate_reg);
  wire lock_up   = ext_mode && !ext_lock_reg && wc_rise && wc_hit && (good_reg == `LOCK_GOOD);
  wire lock_down = ext_mode && ext_lock_reg &&
                   (wc_rise ? !wc_hit : (cnt_reg >= `WC_TIMEOUT));
  assign ev = {|clip_new, lock_down, lock_up};

  // ----------------------------------------------------------------
  // output routing on each frame
  // ----------------------------------------------------------------
  reg [191:0] r1;
  reg [191:0] r2;
  reg [2:0]   c1;
  reg [2:0]   c2;
  integer     k;

  always @*
  begin
    r1 = 192'd0;
    r2 = 192'd0;
    c1 = 3'd0;
    c2 = 3'd0;
    for (k = 0; k < 8; k = k + 1)
    begin
      if (eff_rate < `RATE_88K2)
      begin
        c1 = k[2:0];
        c2 = k[2:0];
      end
      else if (eff_rate < `RATE_176K4)
      begin
        c1 = {1'b0, k[2:1]};
        c2 = {1'b1, k[2:1]};
      end
      else
      begin
        c1 = {2'b00, k[2]};
        c2 = {2'b01, k[2]};
      end
      r1[k*24 +: 24] = word_all[c1*24 +: 24];
      r2[k*24 +: 24] = word_all[c2*24 +: 24];
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      adc_reg    <= 192'd0;
      aes_reg    <= 192'd0;
      opt1_reg   <= 192'd0;
      opt2_reg   <= 192'd0;
      lock_g_reg <= 1'b0;
      lock_r_reg <= 1'b1;
      rate_reg   <= `RATE_48K;
    end
    else
    begin
      if (adc_valid_i)
        adc_reg <= adc_data_i;
      // muting does not wait for a frame, so stale audio never lingers
      if (frame_reg || muted)
      begin
        aes_reg  <= muted ? 192'd0 : word_all;
        opt1_reg <= muted ? 192'd0 : r1;
        opt2_reg <= muted ? 192'd0 : r2;
      end
      lock_g_reg <= locked;
      lock_r_reg <= !locked;
      rate_reg   <= eff_rate;
    end
  end

  assign dat_o            = dat_reg;
  assign ack_o            = ack_reg;
  assign irq_o            = irq_reg;
  assign wc_o             = wc_out_reg;
  assign rate_o           = rate_reg;
  assign frame_o          = frame_reg;
  assign aes_data_o       = aes_reg;
  assign opt1_data_o      = opt1_reg;
  assign opt2_data_o      = opt2_reg;
  assign led_low_green_o  = low_led;
  assign led_up_yellow_o  = yel_led;
  assign led_up_red_o     = red_led;
  assign led_lock_green_o = lock_g_reg;
  assign led_lock_red_o   = lock_r_reg;

endmodule // converter_clock_router

// ==== wc_source.sv ====
`timescale 1ns/1ps
module wc_source (
  input  wire logic        run_i,
  input  wire logic [31:0] half_i,
  output logic             wc_o
);
  // ---------------------------------------
  // far-end word clock master
  // ---------------------------------------
  initial wc_o = 1'b0;

  // stands still low outside a run, so a dead cable looks dead
  always
  begin
    if (run_i === 1'b1)
    begin
      #(half_i) wc_o = ~wc_o;
    end
    else
    begin
      wc_o = 1'b0;
      @(run_i);
      // start off the sampling edge so the synchroniser sees no race
      #13;
    end
  end
endmodule // wc_source

// ==== clock_router_sva.sv ====
`timescale 1ns/1ps
module clock_router_sva (
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire logic         cyc_i,
  input wire logic         stb_i,
  input wire logic         ack_o,
  input wire logic         wc_o,
  input wire logic         frame_o,
  input wire logic [2:0]   rate_o,
  input wire logic [191:0] aes_data_o,
  input wire logic [191:0] opt1_data_o,
  input wire logic [191:0] opt2_data_o,
  input wire logic [7:0]   led_up_yellow_o,
  input wire logic [7:0]   led_up_red_o,
  input wire logic         led_lock_green_o,
  input wire logic         led_lock_red_o
);
  // ---------------------------------------
  // properties
  // ---------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence ans_s;
    ack_o ##1 !ack_o;
  endsequence
  sequence new_frame_s;
    frame_o ##1 $stable(rate_o);
  endsequence

  a_ack_answer: assert property (req_s |=> ans_s)
    else $error("bus answer missing");
  a_lock_excl: assert property (led_lock_green_o != led_lock_red_o)
    else $error("lock leds wrong");
  a_unlock_rate: assert property (led_lock_red_o [*2] |-> rate_o == 3'h1)
    else $error("unlocked rate not 48k");
  a_unlock_mute: assert property (led_lock_red_o [*3] |-> aes_data_o == '0
    && opt1_data_o == '0 && opt2_data_o == '0) else $error("not muted");
  a_frame_follow: assert property ($rose(wc_o) |=> frame_o)
    else $error("frame missing");
  a_frame_single: assert property (frame_o |=> !frame_o)
    else $error("frame too long");
  a_base_mirror: assert property (new_frame_s ##0 rate_o < 3'h2 |->
    opt1_data_o == opt2_data_o) else $error("optical ports differ");
  a_quad_route: assert property (new_frame_s ##0 rate_o >= 3'h4 |->
    opt1_data_o[23:0] == opt1_data_o[71:48] && opt2_data_o[23:0] == opt2_data_o[95:72])
    else $error("quad routing wrong");
  a_red_wins: assert property ((led_up_red_o & led_up_yellow_o) == 8'h00)
    else $error("red and yellow both lit");
endmodule // clock_router_sva

bind converter_clock_router clock_router_sva clock_router_sva_i (.*);

// ==== converter_clock_router_bench.sv ====
`timescale 1ns/1ps
module converter_clock_router_bench;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         cyc_i = 1'b0;
  logic         stb_i = 1'b0;
  logic         we_i = 1'b0;
  logic         adc_valid_i = 1'b0;
  logic         run = 1'b0;
  logic [7:0]   adr_i = 8'h00;
  logic [31:0]  dat_i = 32'h0;
  logic [31:0]  half = 32'h1458;
  logic [31:0]  rd;
  logic [191:0] adc_data_i = '0;
  wire          wc_i, wc_o, frame_o, ack_o, irq_o, led_lock_green_o, led_lock_red_o;
  wire [31:0]   dat_o;
  wire [2:0]    rate_o;
  wire [191:0]  aes_data_o, opt1_data_o, opt2_data_o;
  wire [7:0]    led_low_green_o, led_up_yellow_o, led_up_red_o;
  integer       n_mismatch = 0, num_checks = 0, k, r, s, p;
  int           hz [6] = '{44100, 48000, 88200, 96000, 176400, 192000};

  always #50 clk_i = ~clk_i;

  converter_clock_router #(.HOLD_CYCLES(50)) converter_clock_router_i (.*, .sel_i(4'hF));
  wc_source wc_source_i (.run_i(run), .half_i(half), .wc_o(wc_i));

  // ---------------------------------------
  // helpers
  // ---------------------------------------
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    num_checks = num_checks + 1;
    if (ok !== 1'b1)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  function logic sig(input integer w);
    sig = (w == 0) ? wc_o : (w == 1) ? led_lock_green_o : (w == 2) ? wc_i : ack_o;
  endfunction
  // every wait is bounded; a hang ends the run
  task wait_for(input integer w, input logic v, input integer lim);
    k = 0;
    while (sig(w) !== v && k < lim)
    begin
      @(posedge clk_i);
      k = k + 1;
    end
    if (sig(w) !== v)
    begin
      chk(1'b0, "wait timed out");
      stop_test;
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    wait_for(3, 1'b1, 20);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task meas;
    wait_for(0, 1'b0, 300);
    wait_for(0, 1'b1, 300);
    wait_for(0, 1'b0, 300);
    p = k;
    wait_for(0, 1'b1, 300);
    p = p + k;
  endtask
  function logic [23:0] smp(input integer c);
    smp = 24'h0A0A0A * (c + 1);
  endfunction
  function integer src(input integer rt, input integer pt, input integer sl);
    if (rt < 2)
      src = sl;
    else if (rt < 4)
      src = pt * 4 + sl / 2;
    else
      src = pt * 2 + sl / 4;
  endfunction

  // ---------------------------------------
  // main sequence
  // ---------------------------------------
  initial
  begin
    tick(12);
    chk(led_lock_red_o === 1'b1 && irq_o === 1'b0 && wc_o === 1'b0, "reset state");
    rst_i <= 1'b0;
    tick(2);
    chk(led_lock_green_o === 1'b1 && rate_o === 3'h1, "internal lock");
    wb(1'b0, 8'h00, 32'h0);
    chk(rd === 32'h3, "ctrl reset");
    wb(1'b0, 8'h1C, 32'h0);
    chk(rd === 32'h0, "unmapped read");
    for (s = 0; s < 8; s++)
      adc_data_i[s*24 +: 24] <= smp(s);
    adc_valid_i <= 1'b1;
    tick(1);
    adc_valid_i <= 1'b0;
    for (r = 0; r < 6; r++)
    begin
      wb(1'b1, 8'h00, (r << 1) | 1);
      meas;
      chk(p >= 10000000 / hz[r] && p <= 10000000 / hz[r] + 1, "wc period");
      chk(rate_o === r[2:0], "rate code");
      tick(3);
      for (s = 0; s < 8; s++)
      begin
        chk(aes_data_o[s*24 +: 24] === smp(s), "aes slot");
        chk(opt1_data_o[s*24 +: 24] === smp(src(r, 0, s)), "opt1");
        chk(opt2_data_o[s*24 +: 24] === smp(src(r, 1, s)), "opt2");
      end
      chk(led_low_green_o[0] === 1'b1 && led_low_green_o[7] === 1'b0, "low led");
      chk(led_up_yellow_o[7] === 1'b1 && led_up_red_o[7] === 1'b0, "upper led");
    end
    adc_data_i[23:0] <= 24'h0A0A80;
    adc_valid_i <= 1'b1;
    wb(1'b1, 8'h00, 32'h2);
    adc_valid_i <= 1'b0;
    s = 0;
    r = 0;
    // half way between two 16-bit codes: only dither lands on both
    repeat (10)
    begin
      meas;
      tick(3);
      chk(aes_data_o[7:0] === 8'h00 && aes_data_o[23:9] === 15'h0505, "dithered word");
      s = s + (aes_data_o[8] === 1'b0);
      r = r + (aes_data_o[8] === 1'b1);
    end
    chk(s > 0 && r > 0, "dither spread");
    wb(1'b1, 8'h0C, 32'h2);
    run <= 1'b1;
    wb(1'b1, 8'h00, 32'hD);
    tick(3);
    wait_for(1, 1'b1, 3000);
    chk(rate_o === 3'h3, "slave rate");
    wb(1'b0, 8'h04, 32'h0);
    chk(rd[1:0] === 2'h3, "slave status");
    wait_for(2, 1'b0, 300);
    wait_for(2, 1'b1, 300);
    wait_for(0, 1'b1, 20);
    chk(k >= 2 && k <= 6, "mirror lag");
    wb(1'b0, 8'h08, 32'h0);
    chk(irq_o === 1'b0, "irq masked");
    run <= 1'b0;
    wait_for(1, 1'b0, 1000);
    tick(4);
    chk(irq_o === 1'b1, "irq raised");
    wb(1'b0, 8'h08, 32'h0);
    chk(rd[1] === 1'b1, "lock lost flag");
    tick(2);
    chk(irq_o === 1'b0, "irq cleared");
    half <= 32'h190;
    run <= 1'b1;
    tick(3000);
    chk(led_lock_red_o === 1'b1 && rate_o === 3'h1, "out of window");
    chk(aes_data_o === '0 && opt1_data_o === '0, "muted");
    meas;
    chk(p >= 208 && p <= 209, "fallback wc");
    run <= 1'b0;
    wb(1'b1, 8'h00, 32'h3);
    adc_data_i[23:0] <= 24'h7FFFFF;
    adc_valid_i <= 1'b1;
    tick(1);
    adc_data_i[23:0] <= 24'h000000;
    tick(1);
    adc_valid_i <= 1'b0;
    tick(4);
    chk(led_up_red_o[0] === 1'b1 && irq_o === 1'b0, "clip shown");
    tick(30);
    chk(led_up_red_o[0] === 1'b1, "peak held");
    tick(30);
    chk(led_up_red_o[0] === 1'b0, "peak released");
    stop_test;
  end
endmodule // converter_clock_router_bench
